/* File: logic/pdc_top.sv */
/*
 Always-on power domain controller: three printed power registers,
 an isolation force word, a status word, and a minimal sleep state
 machine. Assumes synchronous sleep and processor-sleep requests.
*/
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pdc_top (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic SLEEP_REQ,
  input wire logic CPU_ASLEEP,
  output logic REGULATOR_ON,
  output logic REGULATOR_LOW,
  output logic BOOST_ON,
  output logic [2:0] AO_BIAS,
  output logic [2:0] CORE_BIAS,
  output logic [7:0] SLOW_OSC_TRIM,
  output logic PERI_POWER_ON,
  output logic PERI_ISOLATE,
  output logic SLOW_RET_POWER_ON,
  output logic SLOW_RET_LOWPOWER_OFF,
  output logic SLOW_RET_ISOLATE,
  output logic FAST_RET_POWER_ON,
  output logic FAST_RET_LOWPOWER_OFF,
  output logic FAST_RET_ISOLATE,
  output logic [7:0] DOMAIN_POWER_ON,
  output logic [7:0] DOMAIN_ISOLATE,
  output logic ASLEEP
);
  logic [31:0] vreg_q;
  logic [31:0] aopwr_q;
  logic [31:0] digpwr_q;
  logic [31:0] iso_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  pdc_pkg::pdc_state_t state_q;
  pdc_pkg::pdc_state_t state_d;
  logic sleeping;
  logic [7:0] dom_on;
  logic slow_on;
  logic fast_on;
  logic peri_on;

  // Register writes
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vreg_q <= pdc_pkg::PDC_REGULATOR_RESET;
      aopwr_q <= pdc_pkg::PDC_AO_POWER_RESET;
      digpwr_q <= pdc_pkg::PDC_DIG_POWER_RESET;
      iso_q <= pdc_pkg::PDC_ISO_RESET;
    end else if (WR) begin
      unique case (ADDR)
        pdc_pkg::PDC_REGULATOR_CONTROL: vreg_q <= WDATA;
        pdc_pkg::PDC_ALWAYS_ON_POWER_CONTROL: aopwr_q <= WDATA & pdc_pkg::PDC_AO_POWER_MASK;
        pdc_pkg::PDC_DIGITAL_DOMAIN_POWER_CONTROL: begin
          digpwr_q <= WDATA & pdc_pkg::PDC_DIG_POWER_MASK;
        end
        pdc_pkg::PDC_PROCESSOR_ISO_CONTROL: iso_q <= WDATA & pdc_pkg::PDC_ISO_MASK;
        default: begin
        end
      endcase
    end
  end

  // Reads; unmapped addresses return zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (RD) begin
      unique case (ADDR)
        pdc_pkg::PDC_REGULATOR_CONTROL: rdata_d = vreg_q;
        pdc_pkg::PDC_ALWAYS_ON_POWER_CONTROL: rdata_d = aopwr_q;
        pdc_pkg::PDC_DIGITAL_DOMAIN_POWER_CONTROL: rdata_d = digpwr_q;
        pdc_pkg::PDC_PROCESSOR_ISO_CONTROL: rdata_d = iso_q;
        pdc_pkg::PDC_STATUS: rdata_d = {20'h00000, sleeping, FAST_RET_POWER_ON,
                                        SLOW_RET_POWER_ON, PERI_POWER_ON, dom_on};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign RDATA = rdata_q;

  // Sleep machine: one cycle entry and exit steps so retention isolation
  // is raised before power drops and released after it returns; peri and digital domains isolate automatically only while off
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pdc_pkg::PDC_AWAKE: if (SLEEP_REQ) state_d = pdc_pkg::PDC_ENTER;
      pdc_pkg::PDC_ENTER: state_d = pdc_pkg::PDC_ASLEEP;
      pdc_pkg::PDC_ASLEEP: if (!SLEEP_REQ) state_d = pdc_pkg::PDC_LEAVE;
      pdc_pkg::PDC_LEAVE: state_d = pdc_pkg::PDC_AWAKE;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= pdc_pkg::PDC_AWAKE;
    end else begin
      state_q <= state_d;
    end
  end
  assign sleeping = (state_q == pdc_pkg::PDC_ASLEEP);
  wire iso_auto = (state_q != pdc_pkg::PDC_AWAKE);
  assign ASLEEP = sleeping;

  // Regulator
  assign REGULATOR_ON = vreg_q[pdc_pkg::REG_FORCE_ON] | ~vreg_q[pdc_pkg::REG_FORCE_OFF];
  assign REGULATOR_LOW = vreg_q[pdc_pkg::REG_FORCE_OFF] & ~vreg_q[pdc_pkg::REG_FORCE_ON];
  assign BOOST_ON = vreg_q[pdc_pkg::BOOST_FORCE_ON] | ~vreg_q[pdc_pkg::BOOST_FORCE_OFF];
  assign AO_BIAS = sleeping ? vreg_q[pdc_pkg::AO_BIAS_ASLEEP_LSB +: pdc_pkg::BIAS_W]
                            : vreg_q[pdc_pkg::AO_BIAS_AWAKE_LSB +: pdc_pkg::BIAS_W];
  assign CORE_BIAS = sleeping ? vreg_q[pdc_pkg::CORE_BIAS_ASLEEP_LSB +: pdc_pkg::BIAS_W]
                              : vreg_q[pdc_pkg::CORE_BIAS_AWAKE_LSB +: pdc_pkg::BIAS_W];
  assign SLOW_OSC_TRIM = vreg_q[pdc_pkg::SLOW_OSC_TRIM_LSB +: pdc_pkg::TRIM_W];

  // Always-on domains
  pdc_switch u_peri (
    .force_on(aopwr_q[pdc_pkg::PERI_FORCE_ON]),
    .force_off(aopwr_q[pdc_pkg::PERI_FORCE_OFF]),
    .sleep_off_en(aopwr_q[pdc_pkg::PERI_SLEEP_OFF_EN]),
    .sleeping(sleeping),
    .power_on(peri_on)
  );
  pdc_switch u_slow (
    .force_on(aopwr_q[pdc_pkg::SLOW_FORCE_ON]),
    .force_off(aopwr_q[pdc_pkg::SLOW_FORCE_OFF]),
    .sleep_off_en(aopwr_q[pdc_pkg::SLOW_SLEEP_OFF_EN]),
    .sleeping(sleeping),
    .power_on(slow_on)
  );
  pdc_switch u_fast (
    .force_on(aopwr_q[pdc_pkg::FAST_FORCE_ON]),
    .force_off(aopwr_q[pdc_pkg::FAST_FORCE_OFF]),
    .sleep_off_en(aopwr_q[pdc_pkg::FAST_SLEEP_OFF_EN]),
    .sleeping(sleeping),
    .power_on(fast_on)
  );
  assign PERI_POWER_ON = peri_on;
  assign SLOW_RET_POWER_ON = slow_on;
  assign FAST_RET_POWER_ON = fast_on;

  // Low-power mode power-down source select, forces on top
  wire slow_lp_src = aopwr_q[pdc_pkg::SLOW_TRACK_CPU] ? CPU_ASLEEP : sleeping;
  wire fast_lp_src = aopwr_q[pdc_pkg::FAST_TRACK_CPU] ? CPU_ASLEEP : sleeping;
  assign SLOW_RET_LOWPOWER_OFF = ~aopwr_q[pdc_pkg::SLOW_LP_FORCE_ON]
                                 & (aopwr_q[pdc_pkg::SLOW_LP_FORCE_OFF] | slow_lp_src);
  assign FAST_RET_LOWPOWER_OFF = ~aopwr_q[pdc_pkg::FAST_LP_FORCE_ON]
                                 & (aopwr_q[pdc_pkg::FAST_LP_FORCE_OFF] | fast_lp_src);

  // Isolation: force isolate wins, then force connect, else automatic
  assign PERI_ISOLATE = aopwr_q[pdc_pkg::PERI_FORCE_ISOLATE]
                        | (~aopwr_q[pdc_pkg::PERI_FORCE_CONNECT] & iso_auto & ~peri_on);
  assign SLOW_RET_ISOLATE = aopwr_q[pdc_pkg::SLOW_FORCE_ISOLATE]
                            | (~aopwr_q[pdc_pkg::SLOW_FORCE_CONNECT] & iso_auto);
  assign FAST_RET_ISOLATE = aopwr_q[pdc_pkg::FAST_FORCE_ISOLATE]
                            | (~aopwr_q[pdc_pkg::FAST_FORCE_CONNECT] & iso_auto);

  // Digital domains: core, radio, SRAM banks, ROM
  genvar g;
  generate
    for (g = 0; g < pdc_pkg::NDOM; g++) begin : g_dom
      pdc_switch u_sw (
        .force_on(digpwr_q[pdc_pkg::DOM_FORCE_ON_MSB - 2 * g]),
        .force_off(digpwr_q[pdc_pkg::DOM_FORCE_ON_MSB - 2 * g - 1]),
        .sleep_off_en(digpwr_q[pdc_pkg::DOM_SLEEP_OFF_EN_MSB - g]),
        .sleeping(sleeping),
        .power_on(dom_on[g])
      );
      assign DOMAIN_ISOLATE[g] = iso_q[2 * g + 1]
                                 | (~iso_q[2 * g] & iso_auto & ~dom_on[g]);
    end
  endgenerate
  assign DOMAIN_POWER_ON = dom_on;

  core_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (sleeping && digpwr_q[pdc_pkg::DOM_SLEEP_OFF_EN_MSB] && !digpwr_q[15]) |-> !DOMAIN_POWER_ON[0])
    else $error("core domain powered in sleep");
  fast_force_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    aopwr_q[pdc_pkg::FAST_FORCE_ON] |-> FAST_RET_POWER_ON)
    else $error("fast retention force on ignored");
  slow_sleep_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (!aopwr_q[pdc_pkg::SLOW_SLEEP_OFF_EN] && !aopwr_q[pdc_pkg::SLOW_FORCE_OFF]) |-> SLOW_RET_POWER_ON)
    else $error("slow retention lost power");
  bias_sleep_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    sleeping |-> CORE_BIAS == vreg_q[pdc_pkg::CORE_BIAS_ASLEEP_LSB +: pdc_pkg::BIAS_W])
    else $error("core bias not sleep setting");
  reg_low_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (vreg_q[pdc_pkg::REG_FORCE_OFF] && !vreg_q[pdc_pkg::REG_FORCE_ON]) |-> !REGULATOR_ON)
    else $error("regulator not lowered");
  read_back_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (RD && ADDR == pdc_pkg::PDC_DIGITAL_DOMAIN_POWER_CONTROL) |=> RDATA == $past(digpwr_q))
    else $error("read back mismatch");
  sleep_seq_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_q == pdc_pkg::PDC_AWAKE && SLEEP_REQ) |=> ##1 sleeping)
    else $error("sleep entry late");
  track_cpu_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (aopwr_q[pdc_pkg::SLOW_TRACK_CPU] && !aopwr_q[12] && !aopwr_q[11]) |->
      SLOW_RET_LOWPOWER_OFF == CPU_ASLEEP)
    else $error("slow retention not tracking processor");

  reg_on_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    vreg_q[pdc_pkg::REG_FORCE_ON] |-> (REGULATOR_ON && !REGULATOR_LOW))
    else $error("regulator not kept on");

  low_out_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (vreg_q[pdc_pkg::REG_FORCE_OFF] && !vreg_q[pdc_pkg::REG_FORCE_ON]) |-> REGULATOR_LOW)
    else $error("regulator low output missing");

  bias_awake_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !sleeping |-> CORE_BIAS == vreg_q[pdc_pkg::CORE_BIAS_AWAKE_LSB +: pdc_pkg::BIAS_W])
    else $error("core bias not awake setting");

  osc_trim_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    SLOW_OSC_TRIM == vreg_q[pdc_pkg::SLOW_OSC_TRIM_LSB +: pdc_pkg::TRIM_W])
    else $error("oscillator trim not passed");

  slow_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (sleeping && aopwr_q[pdc_pkg::SLOW_SLEEP_OFF_EN] && !aopwr_q[pdc_pkg::SLOW_FORCE_ON])
      |-> !SLOW_RET_POWER_ON)
    else $error("slow retention powered in sleep");

  fast_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (sleeping && aopwr_q[pdc_pkg::FAST_SLEEP_OFF_EN] && !aopwr_q[pdc_pkg::FAST_FORCE_ON])
      |-> !FAST_RET_POWER_ON)
    else $error("fast retention powered in sleep");

  fast_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (!aopwr_q[pdc_pkg::FAST_SLEEP_OFF_EN] && !aopwr_q[pdc_pkg::FAST_FORCE_OFF])
      |-> FAST_RET_POWER_ON)
    else $error("fast retention lost power");

  fast_forced_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (aopwr_q[pdc_pkg::FAST_FORCE_OFF] && !aopwr_q[pdc_pkg::FAST_FORCE_ON]) |-> !FAST_RET_POWER_ON)
    else $error("fast retention force off ignored");

  slow_force_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    aopwr_q[pdc_pkg::SLOW_FORCE_ON] |-> SLOW_RET_POWER_ON)
    else $error("slow retention force on ignored");

  slow_lp_on_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    aopwr_q[pdc_pkg::SLOW_LP_FORCE_ON] |-> !SLOW_RET_LOWPOWER_OFF)
    else $error("slow low power force on ignored");

  slow_lp_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (aopwr_q[pdc_pkg::SLOW_LP_FORCE_OFF] && !aopwr_q[pdc_pkg::SLOW_LP_FORCE_ON])
      |-> SLOW_RET_LOWPOWER_OFF)
    else $error("slow low power force off ignored");

  slow_track_sm_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (!aopwr_q[pdc_pkg::SLOW_TRACK_CPU] && !aopwr_q[12] && !aopwr_q[11])
      |-> SLOW_RET_LOWPOWER_OFF == sleeping)
    else $error("slow retention not tracking machine");

  fast_track_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (aopwr_q[pdc_pkg::FAST_TRACK_CPU] && !aopwr_q[9] && !aopwr_q[8])
      |-> FAST_RET_LOWPOWER_OFF == CPU_ASLEEP)
    else $error("fast retention not tracking processor");

  fast_track_sm_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (!aopwr_q[pdc_pkg::FAST_TRACK_CPU] && !aopwr_q[9] && !aopwr_q[8])
      |-> FAST_RET_LOWPOWER_OFF == sleeping)
    else $error("fast retention not tracking machine");

  slow_iso_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    aopwr_q[pdc_pkg::SLOW_FORCE_ISOLATE] |-> SLOW_RET_ISOLATE)
    else $error("slow retention force isolate ignored");

  slow_conn_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (aopwr_q[pdc_pkg::SLOW_FORCE_CONNECT] && !aopwr_q[pdc_pkg::SLOW_FORCE_ISOLATE])
      |-> !SLOW_RET_ISOLATE)
    else $error("slow retention force connect ignored");

  fast_iso_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    aopwr_q[pdc_pkg::FAST_FORCE_ISOLATE] |-> FAST_RET_ISOLATE)
    else $error("fast retention force isolate ignored");

  fast_conn_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (aopwr_q[pdc_pkg::FAST_FORCE_CONNECT] && !aopwr_q[pdc_pkg::FAST_FORCE_ISOLATE])
      |-> !FAST_RET_ISOLATE)
    else $error("fast retention force connect ignored");

  radio_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (sleeping && digpwr_q[22] && !digpwr_q[13]) |-> !DOMAIN_POWER_ON[1])
    else $error("radio domain powered in sleep");

  core_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (!digpwr_q[23] && !digpwr_q[14]) |-> DOMAIN_POWER_ON[0])
    else $error("core domain lost power");

  rom_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (sleeping && digpwr_q[16] && !digpwr_q[1]) |-> !DOMAIN_POWER_ON[7])
    else $error("rom powered in sleep");

  core_force_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    digpwr_q[15] |-> DOMAIN_POWER_ON[0])
    else $error("core force on ignored");

  core_forced_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (digpwr_q[14] && !digpwr_q[15]) |-> !DOMAIN_POWER_ON[0])
    else $error("core force off ignored");

  radio_force_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    digpwr_q[13] |-> DOMAIN_POWER_ON[1])
    else $error("radio force on ignored");

  radio_forced_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (digpwr_q[12] && !digpwr_q[13]) |-> !DOMAIN_POWER_ON[1])
    else $error("radio force off ignored");

  sram4_force_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    digpwr_q[11] |-> DOMAIN_POWER_ON[2])
    else $error("sram bank force on ignored");

  sram4_forced_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (digpwr_q[10] && !digpwr_q[11]) |-> !DOMAIN_POWER_ON[2])
    else $error("sram bank force off ignored");

  wake_seq_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (sleeping && !SLEEP_REQ) |=> ##1 (state_q == pdc_pkg::PDC_AWAKE))
    else $error("sleep exit late");
endmodule
`default_nettype wire

/* File: logic/pdc_pkg.sv */
/*
 Package for the always-on power domain control block: register
 indices, field positions, reset values and sleep state encoding.
 Assumes a plain register port addressed by word index.
*/
`default_nettype none
package pdc_pkg;
  localparam logic [7:0] PDC_REGULATOR_CONTROL = 8'h1f;
  localparam logic [7:0] PDC_ALWAYS_ON_POWER_CONTROL = 8'h20;
  localparam logic [7:0] PDC_DIGITAL_DOMAIN_POWER_CONTROL = 8'h21;
  localparam logic [7:0] PDC_PROCESSOR_ISO_CONTROL = 8'h30;
  localparam logic [7:0] PDC_STATUS = 8'h31;
  // Regulator control fields
  localparam int REG_FORCE_ON = 31;
  localparam int REG_FORCE_OFF = 30;
  localparam int BOOST_FORCE_ON = 29;
  localparam int BOOST_FORCE_OFF = 28;
  localparam int AO_BIAS_AWAKE_LSB = 25;
  localparam int AO_BIAS_ASLEEP_LSB = 22;
  localparam int SLOW_OSC_TRIM_LSB = 14;
  localparam int CORE_BIAS_AWAKE_LSB = 11;
  localparam int CORE_BIAS_ASLEEP_LSB = 8;
  localparam int BIAS_W = 3;
  localparam int TRIM_W = 8;
  // Always-on power control fields
  localparam int PERI_SLEEP_OFF_EN = 21;
  localparam int PERI_FORCE_ON = 20;
  localparam int PERI_FORCE_OFF = 19;
  localparam int SLOW_SLEEP_OFF_EN = 18;
  localparam int SLOW_FORCE_ON = 17;
  localparam int SLOW_FORCE_OFF = 16;
  localparam int FAST_SLEEP_OFF_EN = 15;
  localparam int FAST_FORCE_ON = 14;
  localparam int FAST_FORCE_OFF = 13;
  localparam int SLOW_LP_FORCE_ON = 12;
  localparam int SLOW_LP_FORCE_OFF = 11;
  localparam int SLOW_TRACK_CPU = 10;
  localparam int FAST_LP_FORCE_ON = 9;
  localparam int FAST_LP_FORCE_OFF = 8;
  localparam int FAST_TRACK_CPU = 7;
  localparam int PERI_FORCE_CONNECT = 6;
  localparam int PERI_FORCE_ISOLATE = 5;
  localparam int SLOW_FORCE_ISOLATE = 4;
  localparam int SLOW_FORCE_CONNECT = 3;
  localparam int FAST_FORCE_ISOLATE = 2;
  localparam int FAST_FORCE_CONNECT = 1;
  // Digital domain power control fields; domain index 0..7 is
  // core, radio, sram4, sram3, sram2, sram1, sram0, rom
  localparam int NDOM = 8;
  localparam int DOM_SLEEP_OFF_EN_MSB = 23;
  localparam int DOM_FORCE_ON_MSB = 15;
  // Control word reset values and write masks
  localparam logic [31:0] PDC_REGULATOR_RESET = 32'h00000000;
  localparam logic [31:0] PDC_AO_POWER_RESET = 32'h00012925;
  localparam logic [31:0] PDC_DIG_POWER_RESET = 32'h00155550;
  localparam logic [31:0] PDC_DIG_POWER_MASK = 32'h00ffffff;
  localparam logic [31:0] PDC_AO_POWER_MASK = 32'h003ffffe;
  localparam logic [31:0] PDC_ISO_RESET = 32'h00000000;
  localparam logic [31:0] PDC_ISO_MASK = 32'h0000ffff;
  typedef enum logic [1:0] {PDC_AWAKE, PDC_ENTER, PDC_ASLEEP, PDC_LEAVE} pdc_state_t;
endpackage
`default_nettype wire

/* File: logic/pdc_switch.sv */
/*
 One power domain switch: resolves force bits against the sleeping state
 request. Assumes at most one force bit is set by software.
*/
`timescale 1ns/1ps
`default_nettype none
module pdc_switch (
  input wire logic force_on,
  input wire logic force_off,
  input wire logic sleep_off_en,
  input wire logic sleeping,
  output logic power_on
);
  // Force on wins if software sets both, an arbitrary but fixed choice
  assign power_on = force_on | (~force_off & ~(sleep_off_en & sleeping));
endmodule
`default_nettype wire

/* File: tb/tb_power_domain_control.sv */
/*
 Self-checking bench for the power domain controller top level.
 Assumes the plain register port, one clock and asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_power_domain_control;
  logic clk, arst_n, wr, rd, sleep_req, cpu_asleep;
  logic [7:0] addr, osc_trim, dom_on, dom_iso;
  logic [31:0] wdata, rdata, v, w;
  logic reg_on, reg_low, boost_on, peri_on, peri_iso, asleep;
  logic s_on, s_lp, s_iso, f_on, f_lp, f_iso;
  logic [2:0] ao_bias, core_bias;
  logic [7:0] en, exp_on;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  pdc_top u_pdc_top (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SLEEP_REQ(sleep_req), .CPU_ASLEEP(cpu_asleep), .REGULATOR_ON(reg_on),
    .REGULATOR_LOW(reg_low), .BOOST_ON(boost_on), .AO_BIAS(ao_bias), .CORE_BIAS(core_bias),
    .SLOW_OSC_TRIM(osc_trim), .PERI_POWER_ON(peri_on), .PERI_ISOLATE(peri_iso),
    .SLOW_RET_POWER_ON(s_on), .SLOW_RET_LOWPOWER_OFF(s_lp), .SLOW_RET_ISOLATE(s_iso),
    .FAST_RET_POWER_ON(f_on), .FAST_RET_LOWPOWER_OFF(f_lp), .FAST_RET_ISOLATE(f_iso),
    .DOMAIN_POWER_ON(dom_on), .DOMAIN_ISOLATE(dom_iso), .ASLEEP(asleep));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Ceiling well above the under two hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    checks_done = checks_done + 1;
    if (seen !== expd) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Bounded wait, then settle past the enter and leave states
  task automatic sleep_to(input logic s);
    int i;
    @(posedge clk);
    sleep_req <= s;
    for (i = 0; i < 20 && asleep !== s; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
    check(32'(asleep), 32'(s));
  endtask
  task automatic set_cpu(input logic s);
    @(posedge clk);
    cpu_asleep <= s;
    #1;
  endtask
  initial begin
    arst_n = 0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 0;
    rd = 0;
    sleep_req = 0;
    cpu_asleep = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    read(pdc_pkg::PDC_REGULATOR_CONTROL, v);
    check(v, pdc_pkg::PDC_REGULATOR_RESET);
    read(pdc_pkg::PDC_ALWAYS_ON_POWER_CONTROL, v);
    check(v, pdc_pkg::PDC_AO_POWER_RESET);
    read(pdc_pkg::PDC_DIGITAL_DOMAIN_POWER_CONTROL, v);
    check(v, pdc_pkg::PDC_DIG_POWER_RESET);
    read(8'h10, v);
    check(v, 32'h0);
    $display("test reset done");
    w = (32'h1 << pdc_pkg::REG_FORCE_ON) | (32'h5 << pdc_pkg::CORE_BIAS_AWAKE_LSB)
      | (32'h2 << pdc_pkg::CORE_BIAS_ASLEEP_LSB) | (32'ha6 << pdc_pkg::SLOW_OSC_TRIM_LSB);
    write(pdc_pkg::PDC_REGULATOR_CONTROL, w);
    check(32'(reg_on), 32'h1);
    check(32'(core_bias), 32'h5);
    check(32'(osc_trim), 32'ha6);
    check(32'(boost_on), 32'h1);
    read(pdc_pkg::PDC_REGULATOR_CONTROL, v);
    check(v, w);
    sleep_to(1'b1);
    check(32'(core_bias), 32'h2);
    sleep_to(1'b0);
    check(32'(core_bias), 32'h5);
    write(pdc_pkg::PDC_REGULATOR_CONTROL, 32'h1 << pdc_pkg::REG_FORCE_OFF);
    check(32'(reg_low), 32'h1);
    check(32'(reg_on), 32'h0);
    write(pdc_pkg::PDC_REGULATOR_CONTROL, (32'h1 << pdc_pkg::BOOST_FORCE_OFF)
      | (32'h3 << pdc_pkg::AO_BIAS_AWAKE_LSB) | (32'h6 << pdc_pkg::AO_BIAS_ASLEEP_LSB));
    check(32'(boost_on), 32'h0);
    check(32'(ao_bias), 32'h3);
    sleep_to(1'b1);
    check(32'(ao_bias), 32'h6);
    sleep_to(1'b0);
    $display("test regulator done");
    // Enables sit at bit 23-g for domain g
    for (int p = 0; p < 2; p++) begin
      en = (p == 0) ? 8'hff : 8'ha5;
      write(pdc_pkg::PDC_DIGITAL_DOMAIN_POWER_CONTROL, {8'h00, en, 16'h0000});
      check(32'(dom_on), 32'hff);
      for (int g = 0; g < 8; g++) exp_on[g] = ~en[7-g];
      sleep_to(1'b1);
      check(32'(dom_on), 32'(exp_on));
      sleep_to(1'b0);
    end
    // Core forced on, radio forced off, sram4 forced on, sram3 forced off
    w = {8'h00, 8'hff, 16'h9900};
    write(pdc_pkg::PDC_DIGITAL_DOMAIN_POWER_CONTROL, w | 32'hff000000);
    check(32'(dom_on), 32'hf5);
    read(pdc_pkg::PDC_DIGITAL_DOMAIN_POWER_CONTROL, v);
    check(v, w);
    sleep_to(1'b1);
    check(32'(dom_on), 32'h05);
    check(32'(dom_iso), 32'hfa);
    read(pdc_pkg::PDC_STATUS, v);
    check(v, 32'h905);
    sleep_to(1'b0);
    check(32'(dom_iso), 32'h00);
    write(pdc_pkg::PDC_PROCESSOR_ISO_CONTROL, 32'h2);
    check(32'(dom_iso), 32'h01);
    read(pdc_pkg::PDC_PROCESSOR_ISO_CONTROL, v);
    check(v, 32'h2);
    write(pdc_pkg::PDC_PROCESSOR_ISO_CONTROL, 32'h0);
    $display("test digital domains done");
    w = (32'h1 << pdc_pkg::SLOW_SLEEP_OFF_EN) | (32'h1 << pdc_pkg::FAST_SLEEP_OFF_EN)
      | (32'h1 << pdc_pkg::FAST_FORCE_ON) | (32'h1 << pdc_pkg::FAST_FORCE_ISOLATE)
      | (32'h1 << pdc_pkg::SLOW_FORCE_CONNECT);
    write(pdc_pkg::PDC_ALWAYS_ON_POWER_CONTROL, w);
    check(32'(f_iso), 32'h1);
    check(32'(s_on), 32'h1);
    sleep_to(1'b1);
    check(32'(s_on), 32'h0);
    check(32'(f_on), 32'h1);
    check(32'(s_iso), 32'h0);
    check(32'(peri_on), 32'h1);
    check(32'(peri_iso), 32'h0);
    sleep_to(1'b0);
    write(pdc_pkg::PDC_ALWAYS_ON_POWER_CONTROL, 32'h1 << pdc_pkg::FAST_SLEEP_OFF_EN);
    sleep_to(1'b1);
    check(32'(f_on), 32'h0);
    check(32'(s_on), 32'h1);
    sleep_to(1'b0);
    write(pdc_pkg::PDC_ALWAYS_ON_POWER_CONTROL, 32'h1 << pdc_pkg::FAST_FORCE_OFF);
    check(32'(f_on), 32'h0);
    $display("test retention power done");
    w = (32'h1 << pdc_pkg::SLOW_TRACK_CPU) | (32'h1 << pdc_pkg::FAST_TRACK_CPU);
    write(pdc_pkg::PDC_ALWAYS_ON_POWER_CONTROL, w);
    set_cpu(1'b1);
    check(32'(s_lp), 32'h1);
    check(32'(f_lp), 32'h1);
    write(pdc_pkg::PDC_ALWAYS_ON_POWER_CONTROL, w | (32'h1 << pdc_pkg::SLOW_LP_FORCE_ON));
    check(32'(s_lp), 32'h0);
    // Tracking the awake machine while the processor sleeps
    write(pdc_pkg::PDC_ALWAYS_ON_POWER_CONTROL, 32'h1 << pdc_pkg::SLOW_LP_FORCE_OFF);
    check(32'(s_lp), 32'h1);
    check(32'(f_lp), 32'h0);
    write(pdc_pkg::PDC_ALWAYS_ON_POWER_CONTROL, 32'h0);
    check(32'(s_lp), 32'h0);
    set_cpu(1'b0);
    $display("test low power tracking done");
    summarize();
  end
endmodule
`default_nettype wire
